/* File: dif_contacts.sv */
// contact model: external switches that drive the digital input pins
`timescale 1ns/1ps
module dif_contacts
(
   input  wire logic       mclk,    // system clock, only for reference
   input  wire logic [4:0] level,   // contact levels asked by the bench
   output logic      [4:0] pin      // pins toward the drive, high = +24 V
);
   // ***************************************************
   // contacts
   // ***************************************************
   // contacts move a little after the bench asks, never on a rising edge,
   // so the drive sees a truly asynchronous level change
   // open contacts until the bench first moves one
   initial
      pin = 5'h00;

   always @(level)
      pin <= #5 level;
endmodule

/* File: dif_load.sv */
// load-user edge detection with saved-set bookkeeping
`timescale 1ns/1ps
module dif_load
(
   input  wire logic       mclk,       // system clock
   input  wire logic       nrst,       // async reset, active low
   input  wire logic [4:0] di,         // synchronised inputs
   input  wire logic [4:0] sel_mask,   // inputs coded load user
   input  wire logic       motor_enabled,  // motor running
   input  wire logic       mem_cmd_valid,  // memory command strobe
   input  wire logic [3:0] parameter_memory_command, // command value
   output logic            load_user1,     // pulse: load set 1
   output logic            load_user2,     // pulse: load set 2
   output logic            user1_saved,    // set 1 present
   output logic            user2_saved     // set 2 present
);

   // ***************************************************
   // state
   // ***************************************************
   logic [4:0] prev_reg, prev_next;    // last sample
   logic [1:0] warm_reg, warm_next;    // edges since reset release
   logic       seen_reg, seen_next;    // two real samples in hand
   logic       s1_reg, s1_next;        // set 1 saved
   logic       s2_reg, s2_next;        // set 2 saved
   logic       l1_reg, l1_next;        // load 1 pulse
   logic       l2_reg, l2_next;        // load 2 pulse
   logic [4:0] rise, fall;             // edges this cycle

   // edge compare; no edge before a first sample exists
   always_comb
   begin
      rise      = seen_reg ? (di & ~prev_reg & sel_mask) : 5'h00;
      fall      = seen_reg ? (~di & prev_reg & sel_mask) : 5'h00;
      prev_next = di;
      // the sync stages show reset zeros for two edges; comparing with
      // them would invent a rising edge on a pin held high over reset
      warm_next = {warm_reg[0], 1'b1};
      seen_next = warm_reg[1];
      s1_next   = s1_reg;
      s2_next   = s2_reg;
      // memory commands mark a set as stored
      if (mem_cmd_valid && parameter_memory_command == dif_pkg::MEM_SAVE_USER1)
         s1_next = 1'b1;
      if (mem_cmd_valid && parameter_memory_command == dif_pkg::MEM_SAVE_USER2)
         s2_next = 1'b1;
      // refused edges are dropped, never queued
      l1_next = (|rise) && s1_reg && !motor_enabled;
      l2_next = (|fall) && s2_reg && !motor_enabled;
   end

   // registers
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         prev_reg <= dif_pkg::DI_RST;
         warm_reg <= {2{dif_pkg::BIT_RST}};
         seen_reg <= dif_pkg::BIT_RST;
         s1_reg   <= dif_pkg::BIT_RST;
         s2_reg   <= dif_pkg::BIT_RST;
         l1_reg   <= dif_pkg::BIT_RST;
         l2_reg   <= dif_pkg::BIT_RST;
      end
      else
      begin
         prev_reg <= prev_next;
         warm_reg <= warm_next;
         seen_reg <= seen_next;
         s1_reg   <= s1_next;
         s2_reg   <= s2_next;
         l1_reg   <= l1_next;
         l2_reg   <= l2_next;
      end
   end

   assign load_user1  = l1_reg;
   assign load_user2  = l2_reg;
   assign user1_saved = s1_reg;
   assign user2_saved = s2_reg;

   // ***************************************************
   // checks
   // ***************************************************
   property p_load1;
      @(posedge mclk) disable iff (!nrst)
      load_user1 |-> $past(s1_reg) && !$past(motor_enabled);
   endproperty
   a_load1: assert property (p_load1)
      else $error("set 1 loaded without save or while running");

   property p_load2;
      @(posedge mclk) disable iff (!nrst)
      (seen_reg && s2_reg && !motor_enabled && |(~di & prev_reg & sel_mask))
      |=> load_user2;
   endproperty
   a_load2: assert property (p_load2)
      else $error("falling edge did not load set 2");

   property p_refuse;
      @(posedge mclk) disable iff (!nrst)
      motor_enabled |=> !load_user1 && !load_user2;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("user set loaded while motor enabled");

   property p_nodefer;
      @(posedge mclk) disable iff (!nrst)
      load_user1 |-> $past(di & ~prev_reg & sel_mask) != 5'h00;
   endproperty
   a_nodefer: assert property (p_nodefer)
      else $error("load pulse without a same-cycle rising edge");

endmodule

/* File: dif_pkg.sv */
// constants shared by the digital input function logic
package dif_pkg;

   // ***************************************************
   // sizes
   // ***************************************************
   localparam int NUM_DI = 5;          // programmable inputs
   localparam int FUNC_W = 5;          // width of one function code
   localparam int SEL_W  = 25;         // all five codes packed

   // ***************************************************
   // input function codes
   // ***************************************************
   localparam logic [4:0] FN_START_STOP = 5'h01;  // start/stop
   localparam logic [4:0] FN_GEN_ENABLE = 5'h02;  // general enable
   localparam logic [4:0] FN_INCH_FWD   = 5'h0A;  // inch forward
   localparam logic [4:0] FN_INCH_REV   = 5'h0B;  // inch reverse
   localparam logic [4:0] FN_MULTISPEED = 5'h07;  // multispeed
   localparam logic [4:0] FN_FIELDBUS   = 5'h12;  // remote input
   localparam logic [4:0] FN_FS_DISABLE = 5'h13;  // flying start off
   localparam logic [4:0] FN_LOAD_USER  = 5'h14;  // load user set
   localparam logic [4:0] FN_EDIT_INHIB = 5'h15;  // edit inhibit

   // ***************************************************
   // mode and command values
   // ***************************************************
   localparam logic [3:0] MODE_VEC_SENSORLESS = 4'h3;  // vector mode
   localparam logic [3:0] MODE_VEC_ENCODER    = 4'h4;  // vector mode
   localparam logic [3:0] REF_MULTISPEED      = 4'h8;  // reference src
   localparam logic [3:0] MEM_SAVE_USER1      = 4'hA;  // save set 1
   localparam logic [3:0] MEM_SAVE_USER2      = 4'hB;  // save set 2

   // ***************************************************
   // masks and reset values
   // ***************************************************
   localparam logic [4:0] MS_ELIGIBLE = 5'h0E;  // inputs 1..3 only
   localparam logic [4:0] DI_RST      = 5'h00;  // sampled input reset
   localparam logic       BIT_RST     = 1'b0;   // single flag reset

   // one bit per input whose code equals the given function
   function automatic logic [4:0] fn_match(input logic [24:0] sel,
                                           input logic [4:0]  code);
      logic [4:0] m;
      m = 5'h00;
      for (int i = 0; i < NUM_DI; i++)
         m[i] = (sel[i*FUNC_W +: FUNC_W] == code);
      return m;
   endfunction

endpackage

/* File: dif_sync.sv */
// two-stage synchroniser for the raw digital input pins
`timescale 1ns/1ps
module dif_sync
(
   input  wire logic       mclk,    // system clock
   input  wire logic       nrst,    // async reset, active low
   input  wire logic [4:0] pin,     // raw pins
   output logic      [4:0] sync     // synchronised levels
);

   // ***************************************************
   // two flops; stage one feeds stage two only
   // ***************************************************
   logic [4:0] meta_reg;            // first stage
   logic [4:0] meta_next;           // first stage next
   logic [4:0] sync_reg;            // second stage
   logic [4:0] sync_next;           // second stage next

   // next values
   always_comb
   begin
      meta_next = pin;
      sync_next = meta_reg;
   end

   // registers
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_reg <= dif_pkg::DI_RST;
         sync_reg <= dif_pkg::DI_RST;
      end
      else
      begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync = sync_reg;

endmodule

/* File: dif_top.sv */
// digital input function logic: maps input levels to drive commands
`timescale 1ns/1ps
module dif_top
(
   input  wire logic        mclk,                     // 20 MHz clock
   input  wire logic        nrst,                     // async reset, low
   input  wire logic [4:0]  di_pin,                   // raw input pins
   input  wire logic [24:0] input_function_select,    // 5 bits per input
   input  wire logic [3:0]  control_mode_select,      // control mode
   input  wire logic [3:0]  local_reference_source,   // local ref source
   input  wire logic [3:0]  remote_reference_source,  // remote ref source
   input  wire logic        mem_cmd_valid,            // memory cmd strobe
   input  wire logic [3:0]  parameter_memory_command, // memory cmd value
   input  wire logic        motor_enabled,            // motor is enabled
   input  wire logic        password_enable,          // password in force
   input  wire logic        access_password_ok,       // password matches
   input  wire logic        edit_req,                 // edit request pulse
   output logic             inch_forward,             // inch fwd command
   output logic             inch_reverse,             // inch rev command
   output logic [4:0]       fieldbus_inputs,          // remote input image
   output logic             flying_start_disable,     // suppress fly start
   output logic             load_user1,               // load set 1 pulse
   output logic             load_user2,               // load set 2 pulse
   output logic             user1_saved,              // set 1 stored
   output logic             user2_saved,              // set 2 stored
   output logic             edit_ack,                 // edit accepted pulse
   output logic             edit_nak,                 // edit rejected pulse
   output logic             multispeed_valid,         // multispeed usable
   output logic [4:0]       multispeed_sel,           // multispeed levels
   output logic             run_cmd                   // drive may run
);

   // ***************************************************
   // input synchronisation
   // ***************************************************
   logic [4:0] di_s;                 // synchronised levels

   // pins come from switches, so two flops first
   dif_sync u_sync
   (
      .mclk (mclk),
      .nrst (nrst),
      .pin  (di_pin),
      .sync (di_s)
   );

   // ***************************************************
   // function masks
   // ***************************************************
   logic [4:0] m_start;              // start/stop inputs
   logic [4:0] m_gen;                // general enable inputs
   logic [4:0] m_ifwd;               // inch forward inputs
   logic [4:0] m_irev;               // inch reverse inputs
   logic [4:0] m_ms;                 // multispeed inputs
   logic [4:0] m_fb;                 // fieldbus inputs
   logic [4:0] m_fs;                 // flying start disable
   logic [4:0] m_load;               // load user inputs
   logic [4:0] m_inh;                // edit inhibit inputs

   // decode each input's function code
   always_comb
   begin
      m_start = dif_pkg::fn_match(input_function_select, dif_pkg::FN_START_STOP);
      m_gen   = dif_pkg::fn_match(input_function_select, dif_pkg::FN_GEN_ENABLE);
      m_ifwd  = dif_pkg::fn_match(input_function_select, dif_pkg::FN_INCH_FWD);
      m_irev  = dif_pkg::fn_match(input_function_select, dif_pkg::FN_INCH_REV);
      // multispeed is only honoured on its eligible inputs
      m_ms    = dif_pkg::fn_match(input_function_select, dif_pkg::FN_MULTISPEED)
                & dif_pkg::MS_ELIGIBLE;
      m_fb    = dif_pkg::fn_match(input_function_select, dif_pkg::FN_FIELDBUS);
      m_fs    = dif_pkg::fn_match(input_function_select, dif_pkg::FN_FS_DISABLE);
      m_load  = dif_pkg::fn_match(input_function_select, dif_pkg::FN_LOAD_USER);
      m_inh   = dif_pkg::fn_match(input_function_select, dif_pkg::FN_EDIT_INHIB);
   end

   // ***************************************************
   // load user via input
   // ***************************************************
   dif_load u_load
   (
      .mclk                     (mclk),
      .nrst                     (nrst),
      .di                       (di_s),
      .sel_mask                 (m_load),
      .motor_enabled            (motor_enabled),
      .mem_cmd_valid            (mem_cmd_valid),
      .parameter_memory_command (parameter_memory_command),
      .load_user1               (load_user1),
      .load_user2               (load_user2),
      .user1_saved              (user1_saved),
      .user2_saved              (user2_saved)
   );

   // ***************************************************
   // command state
   // ***************************************************
   logic       ifwd_reg, ifwd_next;  // inch forward
   logic       irev_reg, irev_next;  // inch reverse
   logic [4:0] fb_reg, fb_next;      // fieldbus image
   logic       fs_reg, fs_next;      // flying start disable
   logic       ack_reg, ack_next;    // edit accepted
   logic       nak_reg, nak_next;    // edit rejected
   logic       msv_reg, msv_next;    // multispeed valid
   logic [4:0] mss_reg, mss_next;    // multispeed levels
   logic       run_reg, run_next;    // run permission

   logic       mode_vec;             // vector control selected
   logic       ref_ms;               // a reference is multispeed
   logic       inhibit;              // any inhibit input high
   logic       pw_allows;            // password settings allow
   logic       all_gen;              // every enable input high
   logic       all_start;            // every start input high

   // next values for all commands
   always_comb
   begin
      // inching only under vector control
      mode_vec  = (control_mode_select == dif_pkg::MODE_VEC_SENSORLESS)
                  || (control_mode_select == dif_pkg::MODE_VEC_ENCODER);
      ifwd_next = mode_vec && |(di_s & m_ifwd);
      irev_next = mode_vec && |(di_s & m_irev);
      // fieldbus inputs are only reported, never acted on
      fb_next   = di_s & m_fb;
      fs_next   = |(di_s & m_fs);
      // edit gating: inhibit overrides any password state
      inhibit   = |(di_s & m_inh);
      pw_allows = !password_enable || access_password_ok;
      ack_next  = edit_req && !inhibit && pw_allows;
      nak_next  = edit_req && (inhibit || !pw_allows);
      // multispeed needs one reference source set to it
      ref_ms    = (local_reference_source == dif_pkg::REF_MULTISPEED)
                  || (remote_reference_source == dif_pkg::REF_MULTISPEED);
      msv_next  = ref_ms && (m_ms != 5'h00);
      mss_next  = ref_ms ? (di_s & m_ms) : 5'h00;
      // unassigned inputs count as active in the AND
      all_gen   = &(di_s | ~m_gen);
      all_start = &(di_s | ~m_start);
      // with no start input assigned there is no run request
      run_next  = all_gen && all_start && (m_start != 5'h00);
   end

   // register all commands
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         ifwd_reg <= dif_pkg::BIT_RST;
         irev_reg <= dif_pkg::BIT_RST;
         fb_reg   <= dif_pkg::DI_RST;
         fs_reg   <= dif_pkg::BIT_RST;
         ack_reg  <= dif_pkg::BIT_RST;
         nak_reg  <= dif_pkg::BIT_RST;
         msv_reg  <= dif_pkg::BIT_RST;
         mss_reg  <= dif_pkg::DI_RST;
         run_reg  <= dif_pkg::BIT_RST;
      end
      else
      begin
         ifwd_reg <= ifwd_next;
         irev_reg <= irev_next;
         fb_reg   <= fb_next;
         fs_reg   <= fs_next;
         ack_reg  <= ack_next;
         nak_reg  <= nak_next;
         msv_reg  <= msv_next;
         mss_reg  <= mss_next;
         run_reg  <= run_next;
      end
   end

   // ***************************************************
   // outputs, each straight from a flop
   // ***************************************************
   assign inch_forward         = ifwd_reg;
   assign inch_reverse         = irev_reg;
   assign fieldbus_inputs      = fb_reg;
   assign flying_start_disable = fs_reg;
   assign edit_ack             = ack_reg;
   assign edit_nak             = nak_reg;
   assign multispeed_valid     = msv_reg;
   assign multispeed_sel       = mss_reg;
   assign run_cmd              = run_reg;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   property p_inch_mode;
      !mode_vec |=> !inch_forward && !inch_reverse;
   endproperty
   a_inch_mode: assert property (p_inch_mode)
      else $error("inching acted outside vector modes");

   property p_inch_on;
      (mode_vec && |(di_s & m_ifwd)) |=> inch_forward;
   endproperty
   a_inch_on: assert property (p_inch_on)
      else $error("inch forward missed in vector mode");

   property p_fieldbus;
      ##1 fieldbus_inputs == $past(di_s & m_fb);
   endproperty
   a_fieldbus: assert property (p_fieldbus)
      else $error("fieldbus image does not follow inputs");

   property p_flying;
      |(di_s & m_fs) |=> flying_start_disable;
   endproperty
   a_flying: assert property (p_flying)
      else $error("flying start not suppressed");

   property p_inhibit;
      (edit_req && inhibit) |=> edit_nak && !edit_ack;
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("edit accepted while inhibited");

   property p_password;
      (edit_req && !inhibit) |=> (edit_ack == $past(pw_allows));
   endproperty
   a_password: assert property (p_password)
      else $error("edit result ignores password settings");

   property p_multispeed;
      multispeed_valid |-> $past(ref_ms);
   endproperty
   a_multispeed: assert property (p_multispeed)
      else $error("multispeed valid without reference source");

   property p_gen_enable;
      run_cmd |-> $past(&(di_s | ~m_gen));
   endproperty
   a_gen_enable: assert property (p_gen_enable)
      else $error("run with a general enable input off");

   property p_start_all;
      (|(~di_s & m_start)) |=> !run_cmd;
   endproperty
   a_start_all: assert property (p_start_all)
      else $error("run with a start input off");

   property p_inch_rev_on;
      (mode_vec && |(di_s & m_irev)) |=> inch_reverse;
   endproperty
   a_inch_rev_on: assert property (p_inch_rev_on)
      else $error("inch reverse missed in vector mode");

   property p_inch_idle;
      !(|(di_s & (m_ifwd | m_irev))) |=> !inch_forward && !inch_reverse;
   endproperty
   a_inch_idle: assert property (p_inch_idle)
      else $error("inching without an inch input high");

   property p_flying_off;
      !(|(di_s & m_fs)) |=> !flying_start_disable;
   endproperty
   a_flying_off: assert property (p_flying_off)
      else $error("flying start suppressed with input low");

   property p_pw_reject;
      (edit_req && !pw_allows) |=> edit_nak && !edit_ack;
   endproperty
   a_pw_reject: assert property (p_pw_reject)
      else $error("edit accepted against password settings");

   property p_edit_one;
      edit_req |=> (edit_ack ^ edit_nak);
   endproperty
   a_edit_one: assert property (p_edit_one)
      else $error("edit request not answered exactly once");

   property p_edit_idle;
      !edit_req |=> !edit_ack && !edit_nak;
   endproperty
   a_edit_idle: assert property (p_edit_idle)
      else $error("edit answer without a request");

   property p_ms_off;
      !ref_ms |=> !multispeed_valid && (multispeed_sel == 5'h00);
   endproperty
   a_ms_off: assert property (p_ms_off)
      else $error("multispeed active without reference source");

   property p_run_on;
      (all_gen && all_start && (m_start != 5'h00)) |=> run_cmd;
   endproperty
   a_run_on: assert property (p_run_on)
      else $error("run withheld with all enables and starts on");

endmodule

/* File: dif_top_tb.sv */
// self-checking testbench for the digital input function logic
`timescale 1ns/1ps
module dif_top_tb;
   logic        mclk = 1'b0;       // 20 MHz clock
   logic        nrst = 1'b0;       // reset, active low
   logic [4:0]  contact = 5'h00;   // wanted contact levels
   logic [4:0]  di_pin;            // pins from the contacts
   logic [24:0] sel = 25'h0000000; // packed function codes
   logic [3:0]  mode = 4'h0;       // control mode
   logic [3:0]  lref = 4'h0;       // local reference source
   logic [3:0]  rref = 4'h0;       // remote reference source
   logic [3:0]  mcmd = 4'h0;       // memory command value
   logic        mval = 1'b0;       // memory command strobe
   logic        moten = 1'b0;      // motor enabled
   logic        pwen = 1'b0;       // password in force
   logic        pwok = 1'b0;       // password matches
   logic        ereq = 1'b0;       // edit request
   logic        i_fwd, i_rev, fsd, l1, l2, s1, s2, ack, nak, msv, run;
   logic [4:0]  fb, mss;           // vector outputs
   int          num_errors = 0;    // mismatches
   int          n_tests = 0;       // comparisons
   int          n_l1, n_l2, n_ack, n_nak, cyc = 0; // pulse and cycle counts
   int          seed = 32'h7146;   // random seed
   logic [4:0]  codes [9] = '{5'h01, 5'h02, 5'h0A, 5'h0B, 5'h07, 5'h12, 5'h13, 5'h00, 5'h15};

   always #25 mclk = ~mclk;

   dif_contacts sw_u (.mclk(mclk), .level(contact), .pin(di_pin));

   dif_top dut_u (.mclk(mclk), .nrst(nrst), .di_pin(di_pin), .input_function_select(sel),
      .control_mode_select(mode), .local_reference_source(lref),
      .remote_reference_source(rref), .mem_cmd_valid(mval), .parameter_memory_command(mcmd),
      .motor_enabled(moten), .password_enable(pwen), .access_password_ok(pwok),
      .edit_req(ereq), .inch_forward(i_fwd), .inch_reverse(i_rev), .fieldbus_inputs(fb),
      .flying_start_disable(fsd), .load_user1(l1), .load_user2(l2), .user1_saved(s1),
      .user2_saved(s2), .edit_ack(ack), .edit_nak(nak), .multispeed_valid(msv),
      .multispeed_sel(mss), .run_cmd(run));

   // pulse counters and hang guard; a hang counts as a mismatch
   always @(posedge mclk)
   begin
      n_l1 += (l1 === 1'b1);
      n_l2 += (l2 === 1'b1);
      n_ack += (ack === 1'b1);
      n_nak += (nak === 1'b1);
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         close_out();
      end
   end

   task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
      n_tests++;
      if (g !== e)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_cnt(input string nm, input int e, input int g);
      n_tests++;
      if (g != e)
      begin
         num_errors++;
         $display("Error %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // set contacts and wait past sync, compare and output stages
   task automatic step(input logic [4:0] v);
      @(negedge mclk) contact = v;
      repeat (6) @(negedge mclk);
   endtask

   task automatic mem(input logic [3:0] c);
      @(negedge mclk) mval = 1'b1;
      mcmd = c;
      @(negedge mclk) mval = 1'b0;
   endtask

   // reference model of the level outputs, from settled contacts
   task automatic check_levels();
      logic [4:0] c, efb, emss;
      logic f, r, fs, st_ok, en_ok, st_any, ms_any, ev;
      {efb, emss, f, r, fs, st_any, ms_any} = '0;
      st_ok = 1'b1;
      en_ok = 1'b1;
      ev = (mode == dif_pkg::MODE_VEC_SENSORLESS) || (mode == dif_pkg::MODE_VEC_ENCODER);
      for (int i = 0; i < 5; i++)
      begin
         c = sel[i*5 +: 5];
         f |= (c == dif_pkg::FN_INCH_FWD) && contact[i] && ev;
         r |= (c == dif_pkg::FN_INCH_REV) && contact[i] && ev;
         fs |= (c == dif_pkg::FN_FS_DISABLE) && contact[i];
         if (c == dif_pkg::FN_FIELDBUS) efb[i] = contact[i];
         if (c == dif_pkg::FN_START_STOP) {st_any, st_ok} = {1'b1, st_ok & contact[i]};
         if (c == dif_pkg::FN_GEN_ENABLE) en_ok &= contact[i];
         if (c == dif_pkg::FN_MULTISPEED && dif_pkg::MS_ELIGIBLE[i])
            {ms_any, emss[i]} = {1'b1, contact[i]};
      end
      ev = ms_any && (lref == dif_pkg::REF_MULTISPEED || rref == dif_pkg::REF_MULTISPEED);
      if (!ev) emss = 5'h00;
      chk("inch_forward", 5'(f), 5'(i_fwd));
      chk("inch_reverse", 5'(r), 5'(i_rev));
      chk("fieldbus_inputs", efb, fb);
      chk("flying_start_disable", 5'(fs), 5'(fsd));
      chk("multispeed_valid", 5'(ev), 5'(msv));
      chk("multispeed_sel", emss, mss);
      chk("run_cmd", 5'(st_any & st_ok & en_ok), 5'(run));
   endtask

   initial
   begin
      repeat (20) @(negedge mclk);
      nrst = 1'b1;
      chk("user1_saved", 5'h00, 5'(s1));
      // random codes, contacts, modes and sources
      for (int k = 0; k < 80; k++)
      begin
         @(negedge mclk);
         for (int i = 0; i < 5; i++) sel[i*5 +: 5] = codes[$unsigned($random(seed)) % 9];
         mode = 4'($unsigned($random(seed)) % 6);
         lref = 4'($unsigned($random(seed)) % 10);
         rref = 4'($unsigned($random(seed)) % 10);
         step(5'($random(seed)));
         check_levels();
      end
      // load user set: unsaved, saved, motor enabled, then two inputs at once
      sel = 25'(dif_pkg::FN_LOAD_USER);
      step(5'h00);
      {n_l1, n_l2} = '0;
      step(5'h01);
      step(5'h00);
      chk_cnt("load_user1", 0, n_l1);
      mem(4'hA);
      chk("user1_saved", 5'h01, 5'(s1));
      step(5'h01);
      step(5'h00);
      chk_cnt("load_user1", 1, n_l1);
      chk_cnt("load_user2", 0, n_l2);
      mem(4'hB);
      chk("user2_saved", 5'h01, 5'(s2));
      moten = 1'b1;
      step(5'h01);
      step(5'h00);
      moten = 1'b0;
      repeat (10) @(negedge mclk);
      chk_cnt("load_user1", 1, n_l1);
      chk_cnt("load_user2", 0, n_l2);
      step(5'h01);
      step(5'h00);
      chk_cnt("load_user2", 1, n_l2);
      sel[14:10] = dif_pkg::FN_LOAD_USER;
      step(5'h05);
      chk_cnt("load_user1", 3, n_l1);
      // mid-run reset with load pins held high: flags clear, no false edge
      @(negedge mclk) nrst = 1'b0;
      repeat (3) @(negedge mclk);
      chk("user1_saved", 5'h00, 5'(s1));
      chk("user2_saved", 5'h00, 5'(s2));
      nrst = 1'b1;
      mem(dif_pkg::MEM_SAVE_USER1);
      repeat (6) @(negedge mclk);
      chk_cnt("load_user1", 3, n_l1);
      // edit requests, two back to back, under every inhibit and password case
      sel = 25'(dif_pkg::FN_EDIT_INHIB) << 5;
      for (int k = 0; k < 8; k++)
      begin
         pwen = k[1];
         pwok = k[0];
         step({3'b000, k[2], 1'b0});
         {n_ack, n_nak} = '0;
         ereq = 1'b1;
         repeat (2) @(negedge mclk);
         ereq = 1'b0;
         repeat (3) @(negedge mclk);
         chk_cnt("edit_ack", (!k[2] && (!k[1] || k[0])) ? 2 : 0, n_ack);
         chk_cnt("edit_nak", (!k[2] && (!k[1] || k[0])) ? 0 : 2, n_nak);
      end
      close_out();
   end
endmodule
